// ===== hw/umc_pkg.sv
// Shared constants and carrier types for the usage monitor register bank.
package umc_pkg;
	// Register byte offsets inside the monitor frame.
	localparam logic [11:0] OFS_SEL = 12'h800;
	localparam logic [11:0] OFS_FLT = 12'h820;
	localparam logic [11:0] OFS_CTL = 12'h828;
	localparam logic [11:0] OFS_OCC = 12'h840;

	// Control word field positions.
	localparam int CTL_EN      = 31;
	localparam int CTL_TRIG_LO = 28;
	localparam int CTL_CLR     = 27;
	localparam int CTL_WRAP    = 26;
	localparam int CTL_IRQ     = 25;
	localparam int CTL_STOP    = 24;
	localparam int CTL_GRP_ON  = 17;
	localparam int CTL_PART_ON = 16;
	localparam logic [7:0] CTL_TYPE_CODE = 8'h42;

	// Filter word field positions.
	localparam int FLT_GRP_LO  = 16;
	localparam int FLT_PART_LO = 0;

	// Selector field and occupancy word layout.
	localparam int SEL_W       = 8;
	localparam int CNT_W       = 31;
	localparam int OCC_FLAG    = 31;
	localparam logic [31:0] OCC_RESET = 32'h8000_0000;

	// Snapshot trigger codes.
	localparam logic [2:0] TRIG_NONE  = 3'h0;
	localparam logic [2:0] TRIG_SWREG = 3'h7;

	// Kinds of register access, kept for the answer stage.
	localparam logic [2:0] K_SEL  = 3'h0;
	localparam logic [2:0] K_FLT  = 3'h1;
	localparam logic [2:0] K_CTL  = 3'h2;
	localparam logic [2:0] K_OCC  = 3'h3;
	localparam logic [2:0] K_NONE = 3'h4;

	// Per-monitor configuration as held in the bank.
	typedef struct packed {
		logic        en;
		logic [2:0]  trig;
		logic        clr;
		logic        wrap_seen;
		logic        irq_en;
		logic        stop;
		logic        grp_on;
		logic        part_on;
		logic [7:0]  grp;
		logic [15:0] part;
	} umc_cfg_t;

	// One accepted memory transaction seen by the monitors.
	typedef struct packed {
		logic        valid;
		logic        ns;
		logic [15:0] partition_identifier;
		logic [7:0]  perf_group;
		logic [15:0] bytes;
	} umc_txn_t;

	// One register request on the frame port.
	typedef struct packed {
		logic        req;
		logic        we;
		logic        ns;
		logic [11:0] addr;
		logic [31:0] wdata;
	} umc_req_t;

	// Builds the control word as software reads it.
	function automatic logic [31:0] ctl_word(input umc_cfg_t c);
		return {c.en, c.trig, c.clr, c.wrap_seen, c.irq_en, c.stop,
			6'h00, c.grp_on, c.part_on, 8'h00, CTL_TYPE_CODE};
	endfunction
endpackage

// ===== hw/umc_occ_mem.sv
// Small memory holding the cache occupancy word of every monitor.
`timescale 1ns/1ns
module umc_occ_mem
	import umc_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int IW    = 3
) (
	// Clock and reset.
	input  wire logic          mclk_i,
	input  wire logic          resetn_i,
	// Write port from the cache.
	input  wire logic          we_i,
	input  wire logic [IW-1:0] waddr_i,
	input  wire logic [31:0]   wdata_i,
	// Registered read port.
	input  wire logic [IW-1:0] raddr_i,
	output logic      [31:0]   rdata_o
);
	typedef struct packed {
		logic [DEPTH-1:0][31:0] mem;
		logic [31:0]            rd;
	} umc_mem_t;

	umc_mem_t s;
	umc_mem_t next_s;

	// Read data come from a register, so reads take one edge.
	always_comb begin
		next_s = s;
		next_s.rd = s.mem[raddr_i];
		if (we_i) begin
			next_s.mem[waddr_i] = wdata_i;
		end
	end

	// Every entry starts untrusted until the cache reports it.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= {(DEPTH + 1){OCC_RESET}};
		end else begin
			s <= next_s;
		end
	end

	assign rdata_o = s.rd;
endmodule

// ===== hw/umc_bw_step.sv
// Match and add step for one bandwidth usage monitor.
`timescale 1ns/1ns
module umc_bw_step
	import umc_pkg::*;
(
	// Monitor setting and bank.
	input  wire umc_cfg_t         cfg_i,
	input  wire logic             bank_i,
	// Traffic and current count.
	input  wire umc_txn_t         txn_i,
	input  wire logic [CNT_W-1:0] cnt_i,
	// Results.
	output logic                  hit_o,
	output logic      [CNT_W-1:0] sum_o,
	output logic                  carry_o
);
	logic grp_ok;
	logic part_ok;

	// A cleared match bit lets every value through.
	assign grp_ok  = !cfg_i.grp_on || (txn_i.perf_group == cfg_i.grp);
	assign part_ok = !cfg_i.part_on || (txn_i.partition_identifier == cfg_i.part);

	// Only traffic of the monitor's own security state is counted.
	assign hit_o = txn_i.valid && cfg_i.en && (txn_i.ns == bank_i)
		&& grp_ok && part_ok;

	// The carry out of the counter width is the overflow.
	assign {carry_o, sum_o} = {1'b0, cnt_i}
		+ (CNT_W + 1)'(txn_i.bytes);
endmodule

// ===== hw/umc_regs.sv
// Usage monitor configuration bank with bandwidth counters.
//
// Contract
// - Snapshot optionally clears the bandwidth counter.
// - Without capture, capture fields read zero.
// - Wrap flag sticks until software writes zero.
// - No overflow: wrap and stop fields zero.
// - Interrupt enable raises pulse on each wrap.
// - Counter wraps, then stops when stop set.
// - Subtype and reserved control bits read zero.
// - Group match bit restricts counting by group.
// - Partition match bit restricts by partition.
// - Control low byte reads constant type code.
// - Filter holds group in 23:16, top zero.
// - Filter holds partition identifier in 15:0.
// - Every register banked by access security bit.
// - Selector low byte picks monitor, rest zero.
// - Out-of-range selector flags an error.
// - Top occupancy bit marks value as untrusted.
// - Occupancy low bits give bytes in use.
// - Selector exists only when support flags set.
// - Disabled monitor counts nothing.
// - Trigger field picks snapshot event source.
`timescale 1ns/1ns
module umc_regs
	import umc_pkg::*;
#(
	parameter int         MONITOR_COUNT       = 4,
	parameter bit         HAS_CAPTURE   = 1'b1,
	parameter bit         CAN_OVERFLOW  = 1'b1,
	parameter bit         HAS_OVF_IRQ   = 1'b1,
	parameter logic [5:0] EVT_IMPL      = 6'h3f,
	parameter bit         MON_SUPPORTED = 1'b1,
	parameter bit         IMPL_ID_SUPP  = 1'b0
) (
	// Clock and reset.
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// Register frame port.
	input  wire umc_req_t   bus_i,
	output logic     [31:0] rdata_o,
	output logic            ack_o,
	output logic            err_o,
	// Traffic and snapshot events.
	input  wire umc_txn_t   txn_i,
	input  wire logic [5:0] snap_evt_i,
	input  wire logic [1:0] snap_swreg_i,
	// Occupancy reports from the cache.
	input  wire logic       occ_we_i,
	input  wire logic       occ_ns_i,
	input  wire logic [7:0] occ_idx_i,
	input  wire logic [31:0] occ_word_i,
	// Overflow interrupt pulse.
	output logic            wrap_irq_o
);
	localparam int NM2 = 2 * MONITOR_COUNT;
	localparam int IW  = $clog2(NM2);
	localparam bit SEL_PRESENT = MON_SUPPORTED || IMPL_ID_SUPP;

	// The selector is eight bits wide, so more monitors cannot be reached.
	if (MONITOR_COUNT < 1 || MONITOR_COUNT > 256) begin : g_bad_count
		$error("MONITOR_COUNT must lie between 1 and 256");
	end

	typedef struct packed {
		logic [1:0][SEL_W-1:0]     sel;
		umc_cfg_t [NM2-1:0]        cfg;
		logic [NM2-1:0][CNT_W-1:0] cnt;
		logic [NM2-1:0][CNT_W-1:0] snap;
		logic                      pend;
		logic                      pend_oob;
		logic [2:0]                kind;
		logic [31:0]               pdata;
		logic [31:0]               rdata;
		logic                      ack;
		logic                      err;
		logic                      irq;
	} umc_state_t;

	umc_state_t s;
	umc_state_t next_s;

	logic [NM2-1:0]            hit;
	logic [NM2-1:0][CNT_W-1:0] sum;
	logic [NM2-1:0]            carry;
	logic [NM2-1:0]            fire;
	logic [NM2-1:0]            wrap_evt;
	logic [31:0]               occ_rd;
	logic                      occ_ok;
	logic                      take;
	logic                      bank;
	logic                      oob;
	logic [IW-1:0]             idx;

	// Flat monitor number: secure bank first, then non-secure bank.
	function automatic logic [IW-1:0] flat_idx(input logic ns,
		input logic [7:0] sel);
		return ns ? IW'(MONITOR_COUNT) + IW'(sel) : IW'(sel);
	endfunction

	// Snapshot source decode; absent sources never fire.
	function automatic logic trig_fire(input logic [2:0] t,
		input logic b);
		if (t == TRIG_NONE) begin
			return 1'b0;
		end else if (t == TRIG_SWREG) begin
			return snap_swreg_i[b];
		end else begin
			return snap_evt_i[3'(t - 3'h1)] & EVT_IMPL[3'(t - 3'h1)];
		end
	endfunction

	// Request decode for the current cycle.
	assign take = bus_i.req && !s.pend;
	assign bank = bus_i.ns;
	assign oob  = {1'b0, s.sel[bank]} >= 9'(MONITOR_COUNT);
	assign idx  = flat_idx(bank, s.sel[bank]);
	assign occ_ok = occ_we_i && ({1'b0, occ_idx_i} < 9'(MONITOR_COUNT));

	// One match and add step per monitor.
	for (genvar i = 0; i < NM2; i++) begin : g_mon
		umc_bw_step u_step (
			.cfg_i   (s.cfg[i]),
			.bank_i  (i >= MONITOR_COUNT),
			.txn_i   (txn_i),
			.cnt_i   (s.cnt[i]),
			.hit_o   (hit[i]),
			.sum_o   (sum[i]),
			.carry_o (carry[i])
		);
		assign fire[i] = HAS_CAPTURE
			&& trig_fire(s.cfg[i].trig, i >= MONITOR_COUNT);
	end

	// Occupancy words are looked up for the selected monitor.
	umc_occ_mem #(
		.DEPTH (NM2),
		.IW    (IW)
	) u_occ (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.we_i     (occ_ok),
		.waddr_i  (flat_idx(occ_ns_i, occ_idx_i)),
		.wdata_i  (occ_word_i),
		.raddr_i  (idx),
		.rdata_o  (occ_rd)
	);

	// Counters, snapshots, then register access; a write answers two
	// edges later, like a read, so software sees one fixed latency.
	always_comb begin
		next_s = s;
		wrap_evt = '0;
		next_s.ack = 1'b0;
		next_s.err = 1'b0;
		next_s.irq = 1'b0;
		next_s.pend = 1'b0;
		for (int i = 0; i < NM2; i++) begin
			// A stopped monitor takes no increments until the flag clears.
			if (hit[i] && !(s.cfg[i].stop && s.cfg[i].wrap_seen)) begin
				next_s.cnt[i] = sum[i];
				wrap_evt[i] = carry[i];
			end
			if (wrap_evt[i]) begin
				next_s.cfg[i].wrap_seen = CAN_OVERFLOW;
				next_s.irq = next_s.irq | s.cfg[i].irq_en;
			end
			// The clear wins over a same-cycle increment.
			if (fire[i]) begin
				next_s.snap[i] = s.cnt[i];
				if (s.cfg[i].clr) begin
					next_s.cnt[i] = '0;
				end
			end
		end
		// Answer stage: occupancy comes from the memory register.
		if (s.pend) begin
			next_s.ack = 1'b1;
			next_s.err = s.pend_oob;
			next_s.rdata = (s.kind == K_OCC && !s.pend_oob)
				? occ_rd : s.pdata;
		end
		// Request stage.
		if (take) begin
			next_s.pend = 1'b1;
			next_s.pend_oob = 1'b0;
			next_s.pdata = '0;
			if (bus_i.addr == OFS_SEL) begin
				next_s.kind = K_SEL;
				if (SEL_PRESENT) begin
					next_s.pdata = {24'h0, s.sel[bank]};
					if (bus_i.we) begin
						next_s.sel[bank] = bus_i.wdata[SEL_W-1:0];
					end
				end
			end else if (bus_i.addr == OFS_FLT) begin
				next_s.kind = K_FLT;
				next_s.pend_oob = oob;
				if (!oob) begin
					next_s.pdata = {8'h00, s.cfg[idx].grp,
						s.cfg[idx].part};
					if (bus_i.we) begin
						next_s.cfg[idx].grp =
							bus_i.wdata[FLT_GRP_LO +: 8];
						next_s.cfg[idx].part =
							bus_i.wdata[FLT_PART_LO +: 16];
					end
				end
			end else if (bus_i.addr == OFS_CTL) begin
				next_s.kind = K_CTL;
				next_s.pend_oob = oob;
				if (!oob) begin
					next_s.pdata = ctl_word(s.cfg[idx]);
					if (bus_i.we) begin
						next_s.cfg[idx].en = bus_i.wdata[CTL_EN];
						next_s.cfg[idx].trig = HAS_CAPTURE
							? bus_i.wdata[CTL_TRIG_LO +: 3]
							: TRIG_NONE;
						next_s.cfg[idx].clr = HAS_CAPTURE
							&& bus_i.wdata[CTL_CLR];
						// A wrap in this very cycle beats the clear.
						next_s.cfg[idx].wrap_seen = CAN_OVERFLOW
							&& (bus_i.wdata[CTL_WRAP]
							|| wrap_evt[idx]);
						next_s.cfg[idx].irq_en = HAS_OVF_IRQ
							&& bus_i.wdata[CTL_IRQ];
						next_s.cfg[idx].stop = CAN_OVERFLOW
							&& bus_i.wdata[CTL_STOP];
						next_s.cfg[idx].grp_on =
							bus_i.wdata[CTL_GRP_ON];
						next_s.cfg[idx].part_on =
							bus_i.wdata[CTL_PART_ON];
					end
				end
			end else if (bus_i.addr == OFS_OCC) begin
				// The occupancy is a measurement; writes are dropped.
				next_s.kind = K_OCC;
				next_s.pend_oob = oob;
			end else begin
				next_s.kind = K_NONE;
			end
		end
	end

	// Single state register; configuration clears to disabled.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_o    = s.rdata;
	assign ack_o      = s.ack;
	assign err_o      = s.err;
	assign wrap_irq_o = s.irq;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_snap_clear: assert property (
		fire[0] && s.cfg[0].clr |=> s.cnt[0] == '0 && s.snap[0] ==
			$past(s.cnt[0]))
		else $error("counter not cleared after snapshot");
	a_capt_absent: assert property (
		!HAS_CAPTURE |-> s.cfg[0].trig == TRIG_NONE && !s.cfg[0].clr)
		else $error("capture fields set without capture");
	a_wrap_sticky: assert property (
		wrap_evt[0] && CAN_OVERFLOW |=> s.cfg[0].wrap_seen [*2])
		else $error("wrap flag did not stick");
	a_wrap_irq: assert property (
		wrap_evt[0] && s.cfg[0].irq_en |=> wrap_irq_o)
		else $error("no interrupt on wrap");
	a_stop_hold: assert property (
		s.cfg[0].stop && s.cfg[0].wrap_seen && !fire[0]
			|=> $stable(s.cnt[0]))
		else $error("stopped counter moved");
	a_ctl_reserved: assert property (
		ack_o && s.kind == K_CTL |-> rdata_o[23:18] == 6'h00
			&& rdata_o[15:8] == 8'h00)
		else $error("reserved control bits not zero");
	a_type_code: assert property (
		ack_o && s.kind == K_CTL && !err_o
			|-> rdata_o[7:0] == CTL_TYPE_CODE)
		else $error("wrong type code");
	a_sel_upper: assert property (
		ack_o && s.kind == K_SEL |-> rdata_o[31:8] == 24'h0)
		else $error("selector upper bits not zero");
	a_oob_error: assert property (
		take && oob && bus_i.addr == OFS_CTL |-> ##2 ack_o && err_o)
		else $error("out-of-range access not flagged");
	a_idle_hold: assert property (
		!s.cfg[0].en && !fire[0] |=> $stable(s.cnt[0]))
		else $error("disabled monitor counted");
endmodule

// ===== verification/umc_regs_test.sv
// Self-checking bench for the usage monitor register bank.
`timescale 1ns/1ns
module umc_regs_test
	import umc_pkg::*;
;
	// Design ports.
	logic        mclk_i;
	logic        resetn_i;
	umc_req_t    bus_i;
	umc_txn_t    txn_i;
	logic [5:0]  snap_evt_i;
	logic [1:0]  snap_swreg_i;
	logic        occ_we_i;
	logic        occ_ns_i;
	logic [7:0]  occ_idx_i;
	logic [31:0] occ_word_i;
	logic [31:0] rdata_o;
	logic        ack_o;
	logic        err_o;
	logic        wrap_irq_o;
	// Bench bookkeeping.
	int          err_total;
	int          checks;
	int          irq_cnt;
	int          cycles;

	umc_regs u_dut (
		.mclk_i       (mclk_i),
		.resetn_i     (resetn_i),
		.bus_i        (bus_i),
		.rdata_o      (rdata_o),
		.ack_o        (ack_o),
		.err_o        (err_o),
		.txn_i        (txn_i),
		.snap_evt_i   (snap_evt_i),
		.snap_swreg_i (snap_swreg_i),
		.occ_we_i     (occ_we_i),
		.occ_ns_i     (occ_ns_i),
		.occ_idx_i    (occ_idx_i),
		.occ_word_i   (occ_word_i),
		.wrap_irq_o   (wrap_irq_o)
	);

	// Free-running clock at 100 ns.
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// Counts interrupt pulses and cuts a hang short; two wraps need ~66k.
	always @(posedge mclk_i) begin
		cycles = cycles + 1;
		if (wrap_irq_o === 1'b1) irq_cnt = irq_cnt + 1;
		if (cycles == 90000) begin
			err_total = err_total + 1;
			finish_test();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One register access; entered and left at a falling edge.
	task automatic acc(input logic we, input logic ns, input logic [11:0] a,
		input logic [31:0] wd, input logic [31:0] exp, input logic xerr);
		int n;
		n = 0;
		bus_i = '{req: 1'b1, we: we, ns: ns, addr: a, wdata: wd};
		@(negedge mclk_i);
		bus_i.req = 1'b0;
		while (ack_o !== 1'b1 && n < 4) begin
			@(negedge mclk_i);
			n = n + 1;
		end
		chk({31'h0, ack_o}, 32'h1);
		if (!we) chk(rdata_o, exp);
		chk({31'h0, err_o}, {31'h0, xerr});
	endtask

	task automatic wr(input logic ns, input logic [11:0] a,
		input logic [31:0] d);
		acc(1'b1, ns, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic ns, input logic [11:0] a,
		input logic [31:0] e);
		acc(1'b0, ns, a, 32'h0, e, 1'b0);
	endtask

	// Sends n back-to-back transactions of the largest byte size.
	task automatic send(input int n, input logic ns, input logic [15:0] p,
		input logic [7:0] g);
		txn_i = '{valid: 1'b1, ns: ns, partition_identifier: p, perf_group: g, bytes: 16'hffff};
		repeat (n) @(negedge mclk_i);
		txn_i.valid = 1'b0;
		repeat (2) @(negedge mclk_i);
	endtask

	// Reset contents and an unmapped place.
	task automatic t_reset();
		rd(1'b0, OFS_SEL, 32'h0);
		rd(1'b0, OFS_CTL, 32'h0000_0042);
		rd(1'b1, OFS_FLT, 32'h0);
		rd(1'b0, OFS_OCC, 32'h8000_0000);
		rd(1'b1, 12'h900, 32'h0);
	endtask

	// All-ones writes, with the control wrap bit left zero, show which bits hold and which read zero.
	task automatic t_fields();
		wr(1'b0, OFS_SEL, 32'h0000_0001);
		wr(1'b0, OFS_CTL, 32'hfbff_ffff);
		rd(1'b0, OFS_CTL, 32'hfb03_0042);
		wr(1'b0, OFS_CTL, 32'h0);
		wr(1'b0, OFS_FLT, 32'hffff_ffff);
		rd(1'b0, OFS_FLT, 32'h00ff_ffff);
		wr(1'b0, OFS_SEL, 32'hffff_ffff);
		rd(1'b0, OFS_SEL, 32'h0000_00ff);
		acc(1'b0, 1'b0, OFS_CTL, 32'h0, 32'h0, 1'b1);
		wr(1'b0, OFS_SEL, 32'h0000_0004);
		acc(1'b0, 1'b0, OFS_FLT, 32'h0, 32'h0, 1'b1);
		wr(1'b0, OFS_SEL, 32'h0000_0003);
		rd(1'b0, OFS_FLT, 32'h0);
	endtask

	// Banked selectors, filters and occupancy words.
	task automatic t_bank_occ();
		@(negedge mclk_i);
		occ_we_i = 1'b1;
		occ_idx_i = 8'h02;
		occ_word_i = 32'h0000_1234;
		@(negedge mclk_i);
		occ_ns_i = 1'b1;
		occ_word_i = 32'h8000_5678;
		@(negedge mclk_i);
		occ_we_i = 1'b0;
		wr(1'b0, OFS_SEL, 32'h0000_0002);
		wr(1'b1, OFS_SEL, 32'h0000_0002);
		rd(1'b0, OFS_OCC, 32'h0000_1234);
		rd(1'b1, OFS_OCC, 32'h8000_5678);
		wr(1'b0, OFS_OCC, 32'h0);
		rd(1'b0, OFS_OCC, 32'h0000_1234);
		wr(1'b1, OFS_FLT, 32'h0000_beef);
		rd(1'b1, OFS_FLT, 32'h0000_beef);
		rd(1'b0, OFS_FLT, 32'h0);
	endtask

	// 32768 matching units stay below the wrap; one more wraps.
	task automatic t_count();
		wr(1'b0, OFS_SEL, 32'h0);
		wr(1'b0, OFS_FLT, 32'h005a_1234);
		wr(1'b0, OFS_CTL, 32'h8203_0000);
		send(32768, 1'b0, 16'h1234, 8'h5a);
		send(1, 1'b0, 16'h1235, 8'h5a);
		send(1, 1'b0, 16'h1234, 8'h5b);
		send(1, 1'b1, 16'h1234, 8'h5a);
		wr(1'b0, OFS_CTL, 32'h0003_0000);
		send(1, 1'b0, 16'h1234, 8'h5a);
		chk(irq_cnt, 32'h0);
		rd(1'b0, OFS_CTL, 32'h0003_0042);
		wr(1'b0, OFS_CTL, 32'h8203_0000);
		send(1, 1'b0, 16'h1234, 8'h5a);
		chk(irq_cnt, 32'h1);
		rd(1'b0, OFS_CTL, 32'h8603_0042);
		wr(1'b0, OFS_CTL, 32'h8203_0000);
		rd(1'b0, OFS_CTL, 32'h8203_0042);
	endtask

	// A software snapshot with clearing restarts the count from zero, and
	// the stop bit then holds the wrapped count against more traffic.
	task automatic t_snap();
		wr(1'b0, OFS_CTL, 32'hf903_0000);
		send(1, 1'b0, 16'h1234, 8'h5a);
		snap_swreg_i = 2'b01;
		@(negedge mclk_i);
		snap_swreg_i = 2'b00;
		send(32768, 1'b0, 16'h1234, 8'h5a);
		rd(1'b0, OFS_CTL, 32'hf903_0042);
		send(1, 1'b0, 16'h1234, 8'h5a);
		rd(1'b0, OFS_CTL, 32'hfd03_0042);
		send(1, 1'b0, 16'h1234, 8'h5a);
		chk({1'b0, u_dut.s.cnt[0]}, 32'h0000_7fff);
		repeat (2) @(negedge mclk_i);
		chk(irq_cnt, 32'h1);
	endtask

	// External events: only the selected source snapshots and clears.
	task automatic t_event();
		wr(1'b0, OFS_CTL, 32'h1803_0000);
		snap_evt_i = 6'h3e;
		@(negedge mclk_i);
		snap_evt_i = 6'h00;
		@(negedge mclk_i);
		chk({1'b0, u_dut.s.cnt[0]}, 32'h0000_7fff);
		snap_evt_i = 6'h01;
		@(negedge mclk_i);
		snap_evt_i = 6'h00;
		@(negedge mclk_i);
		chk({1'b0, u_dut.s.cnt[0]}, 32'h0);
		chk({1'b0, u_dut.s.snap[0]}, 32'h0000_7fff);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence: inputs change only at falling edges.
	initial begin
		err_total = 0;
		checks = 0;
		irq_cnt = 0;
		cycles = 0;
		resetn_i = 1'b0;
		bus_i = '0;
		txn_i = '0;
		snap_evt_i = 6'h00;
		snap_swreg_i = 2'b00;
		occ_we_i = 1'b0;
		occ_ns_i = 1'b0;
		occ_idx_i = 8'h00;
		occ_word_i = 32'h0;
		repeat (8) @(negedge mclk_i);
		resetn_i = 1'b1;
		@(negedge mclk_i);
		t_reset();
		t_fields();
		t_bank_occ();
		t_count();
		t_snap();
		t_event();
		finish_test();
	end
endmodule
